// ==== verilog/adc_pkg.sv ====
// constants shared by the converter control and its approximation engine
// assumes nibble-wide memory-mapped registers on a 7-bit data address
package adc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [6:0] ADC_MODE_REG_ADDR   = 7'h16;
  localparam logic [6:0] RESULT_LOW_ADDR     = 7'h17;
  localparam logic [6:0] RESULT_HIGH_ADDR    = 7'h18;
  localparam logic [6:0] SHARED_FLAGS_ADDR   = 7'h20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CONV_LENGTH_BIT    = 0;
  localparam int CHANNEL_SEL_LO_BIT = 2;
  localparam int CHANNEL_SEL_HI_BIT = 3;
  localparam int LOW_SPEED_BIT      = 0;
  localparam int WATCHDOG_BIT       = 1;
  localparam int START_FLAG_BIT     = 2;
  localparam int MODE_A_BIT         = 3;

  // ************************************************************
  // reset values and timing in instruction cycles
  // ************************************************************
  localparam logic [3:0] FLAGS_RESET   = 4'h0;
  localparam logic [1:0] CHANNEL_RESET = 2'h0;
  localparam logic       LENGTH_RESET  = 1'b0;
  localparam logic [7:0] TRIAL_FIRST   = 8'h80;
  localparam logic [6:0] CONV_SHORT    = 7'h22;
  localparam logic [6:0] CONV_LONG     = 7'h43;
  localparam logic [6:0] STEP_SHORT    = 7'h04;
  localparam logic [6:0] STEP_LONG     = 7'h08;
  localparam int         RESULT_BITS   = 8;

  typedef enum logic {ENG_IDLE, ENG_RUN} engine_state_e;

  // conversion length in instruction cycles for the selected period
  function automatic logic [6:0] conv_total(input logic long_sel);
    conv_total = long_sel ? CONV_LONG : CONV_SHORT;
  endfunction : conv_total

  // instruction cycles between two bit decisions
  function automatic logic [6:0] conv_step(input logic long_sel);
    conv_step = long_sel ? STEP_LONG : STEP_SHORT;
  endfunction : conv_step

endpackage : adc_pkg

// ==== verilog/adc_core_if.sv ====
// signals between the register side and the approximation engine
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface adc_core_if;
  logic       tick;      // one instruction cycle, gated off in low power
  logic       start;     // one-cycle launch request
  logic       long_sel;  // conversion period select
  logic       comp;      // synchronised comparator, input above ladder
  logic       busy;
  logic       done;      // one-cycle completion pulse
  logic [7:0] code;      // trial value on the ladder
  logic [7:0] value;     // held result

  modport ctrl   (output tick, start, long_sel, comp, input busy, done, code, value);
  modport engine (input tick, start, long_sel, comp, output busy, done, code, value);
endinterface : adc_core_if

// ==== verilog/adc_sar_engine.sv ====
// successive approximation engine: sequences the eight bit decisions
// assumes ticks are gated while the chip sleeps and comp is synchronised
`timescale 1ns/1ns
module adc_sar_engine
  import adc_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  reset,
  adc_core_if.engine core
);

  // ************************************************************
  // state
  // ************************************************************
  engine_state_e state;
  engine_state_e next_state;
  logic [6:0]    count;
  logic [6:0]    next_count;
  logic [7:0]    code;
  logic [7:0]    next_code;
  logic [7:0]    value;
  logic [7:0]    next_value;
  logic          long_sel;
  logic          next_long_sel;
  logic          done;
  logic          next_done;
  logic [6:0]    pre;
  logic [6:0]    rel;
  logic [2:0]    bit_idx;
  logic          decide;

  // decision points: a short preamble then one decision per step
  always_comb
  begin
    pre     = conv_total(long_sel) - (conv_step(long_sel) << 3);
    rel     = count - pre;
    bit_idx = 3'(RESULT_BITS - 1 - (long_sel ? (rel >> 3) : (rel >> 2)));
    decide  = (count >= pre) && ((rel & (conv_step(long_sel) - 7'h01))
              == (conv_step(long_sel) - 7'h01));
  end

  // next-state logic of the sequencer
  always_comb
  begin
    next_state    = state;
    next_count    = count;
    next_code     = code;
    next_value    = value;
    next_long_sel = long_sel;
    next_done     = 1'b0;
    case (state)
      ENG_IDLE:
      begin
        if (core.start)
        begin
          next_state    = ENG_RUN;
          next_count    = '0;
          next_code     = TRIAL_FIRST;
          next_long_sel = core.long_sel;
        end
      end
      ENG_RUN:
      begin
        if (core.tick)
        begin
          next_count = count + 7'h01;
          if (decide)
          begin
            next_code[bit_idx] = core.comp;
            if (bit_idx != 3'h0)
              next_code[bit_idx - 3'h1] = 1'b1;
          end
          if (count == conv_total(long_sel) - 7'h01)
          begin
            next_state = ENG_IDLE;
            next_done  = 1'b1;
            next_value = {next_code[7:1], core.comp};
          end
        end
      end
      default: next_state = ENG_IDLE;
    endcase
  end

  // control registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state    <= ENG_IDLE;
      count    <= '0;
      code     <= '0;
      long_sel <= LENGTH_RESET;
      done     <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      code     <= next_code;
      long_sel <= next_long_sel;
      done     <= next_done;
    end
  end

  // result survives reset and only changes at completion
  always_ff @(posedge clock)
  begin
    value <= next_value;
  end

  assign core.busy  = (state == ENG_RUN);
  assign core.done  = done;
  assign core.code  = code;
  assign core.value = value;

  // ************************************************************
  // checks
  // ************************************************************
  // value is unknown until the first completion, so compare case-wise
  a_value_held: assert property (@(posedge clock) disable iff (reset)
    !next_done |=> value === $past(value))
    else $error("result changed outside completion");
  a_short_length: assert property (@(posedge clock) disable iff (reset)
    (state == ENG_RUN && tick_last() && !long_sel) |-> count == CONV_SHORT - 7'h01)
    else $error("short conversion length wrong");
  a_long_length: assert property (@(posedge clock) disable iff (reset)
    (state == ENG_RUN && tick_last() && long_sel) |-> count == CONV_LONG - 7'h01)
    else $error("long conversion length wrong");

  function automatic logic tick_last();
    tick_last = core.tick && next_done;
  endfunction : tick_last

endmodule : adc_sar_engine

// ==== verilog/adc_sequencer_control.sv ====
// converter control: mode register, shared flags, result read-back
// assumes nibble register port from the core and an external ladder and comparator
//
// Function
// - convert one of four inputs to eight bits by successive approximation
// - mode bits 3 and 2 pick the input channel zero to three
// - mode bit 0 picks 34 or 67 instruction cycles per conversion
// - result is read-only, two nibbles, and reset leaves it unchanged
// - result stays unchanged from completion until the next conversion completes
// - writing one to the start flag launches a conversion
// - completion loads the result and clears the start flag
// - no conversion progress in stop, watch or subactive modes
// - ladder current is cut in every low-power mode
// - start flag is bit 2 of a shared four-bit flag register, reset zero
`timescale 1ns/1ns
module adc_sequencer_control
  import adc_pkg::*;
#(
  parameter int CYC_DIV = 4  // clocks per instruction cycle
)
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [3:0] reg_wdata,
  input  wire logic       reg_read,
  output      logic [3:0] reg_rdata,
  input  wire logic       low_power,
  input  wire logic       comparator,
  output      logic [7:0] ladder_code,
  output      logic [1:0] analog_input_sel,
  output      logic       ladder_enable,
  output      logic       conversion_busy,
  output      logic       mode_flag_a,
  output      logic       watchdog_enable_flag,
  output      logic       low_speed_flag
);

  adc_core_if core ();

  // ************************************************************
  // state
  // ************************************************************
  logic [1:0] comp_sync;
  logic [$clog2(CYC_DIV+1)-1:0] div_count;
  logic [$clog2(CYC_DIV+1)-1:0] next_div_count;
  logic       tick;
  logic       next_tick;
  logic [1:0] channel;
  logic [1:0] next_channel;
  logic       conv_length_sel;
  logic       next_conv_length_sel;
  logic [3:0] flags;
  logic [3:0] next_flags;
  logic       start;
  logic       next_start;
  logic [3:0] next_rdata;
  logic       wr_mode;
  logic       wr_flags;

  adc_sar_engine engine (
    .clock (clock),
    .reset (reset),
    .core  (core)
  );

  // comparator comes from the analogue side, two flops before use
  always_ff @(posedge clock)
  begin
    if (reset)
      comp_sync <= 2'b00;
    else
      comp_sync <= {comp_sync[0], comparator};
  end

  // instruction-cycle enable, stopped while the oscillator is unavailable
  always_comb
  begin
    next_div_count = div_count;
    next_tick      = 1'b0;
    if (!low_power)
    begin
      if (int'(div_count) == CYC_DIV - 1)
      begin
        next_div_count = '0;
        next_tick      = 1'b1;
      end
      else
        next_div_count = div_count + 1'b1;
    end
  end

  // register writes and start flag handling
  always_comb
  begin
    wr_mode              = reg_write && (reg_addr == ADC_MODE_REG_ADDR);
    wr_flags             = reg_write && (reg_addr == SHARED_FLAGS_ADDR);
    next_channel         = channel;
    next_conv_length_sel = conv_length_sel;
    next_flags           = flags;
    next_start           = 1'b0;
    if (wr_mode)
    begin
      next_channel         = {reg_wdata[CHANNEL_SEL_HI_BIT],
                              reg_wdata[CHANNEL_SEL_LO_BIT]};
      next_conv_length_sel = reg_wdata[CONV_LENGTH_BIT];
    end
    if (core.done)
      next_flags[START_FLAG_BIT] = 1'b0;
    if (wr_flags)
    begin
      next_flags[MODE_A_BIT]    = reg_wdata[MODE_A_BIT];
      next_flags[WATCHDOG_BIT]  = reg_wdata[WATCHDOG_BIT];
      next_flags[LOW_SPEED_BIT] = reg_wdata[LOW_SPEED_BIT];
      // a start write during conversion is forbidden and ignored
      if (reg_wdata[START_FLAG_BIT] && !flags[START_FLAG_BIT])
      begin
        next_flags[START_FLAG_BIT] = 1'b1;
        next_start                 = 1'b1;
      end
    end
  end

  // read mux, registered; write-only and unmapped addresses read zero
  always_comb
  begin
    next_rdata = 4'h0;
    if (reg_read)
    begin
      case (reg_addr)
        RESULT_LOW_ADDR:   next_rdata = core.value[3:0];
        RESULT_HIGH_ADDR:  next_rdata = core.value[7:4];
        SHARED_FLAGS_ADDR: next_rdata = flags;
        default:           next_rdata = 4'h0;
      endcase
    end
  end

  // registers of the control side
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      div_count            <= '0;
      tick                 <= 1'b0;
      channel              <= CHANNEL_RESET;
      conv_length_sel      <= LENGTH_RESET;
      flags                <= FLAGS_RESET;
      start                <= 1'b0;
      reg_rdata            <= 4'h0;
      ladder_code          <= '0;
      analog_input_sel     <= CHANNEL_RESET;
      ladder_enable        <= 1'b0;
      conversion_busy      <= 1'b0;
      mode_flag_a          <= 1'b0;
      watchdog_enable_flag <= 1'b0;
      low_speed_flag       <= 1'b0;
    end
    else
    begin
      div_count            <= next_div_count;
      tick                 <= next_tick;
      channel              <= next_channel;
      conv_length_sel      <= next_conv_length_sel;
      flags                <= next_flags;
      start                <= next_start;
      reg_rdata            <= next_rdata;
      ladder_code          <= core.code;
      analog_input_sel     <= next_channel;
      ladder_enable        <= !low_power;
      conversion_busy      <= next_flags[START_FLAG_BIT];
      mode_flag_a          <= next_flags[MODE_A_BIT];
      watchdog_enable_flag <= next_flags[WATCHDOG_BIT];
      low_speed_flag       <= next_flags[LOW_SPEED_BIT];
    end
  end

  assign core.tick     = tick && !low_power;
  assign core.start    = start;
  assign core.long_sel = conv_length_sel;
  assign core.comp     = comp_sync[1];

  // ************************************************************
  // checks
  // ************************************************************
  a_start_launch: assert property (@(posedge clock) disable iff (reset)
    (wr_flags && reg_wdata[START_FLAG_BIT] && !flags[START_FLAG_BIT])
    |=> flags[START_FLAG_BIT] ##1 core.busy)
    else $error("start write did not launch");
  a_done_clears: assert property (@(posedge clock) disable iff (reset)
    core.done |=> !flags[START_FLAG_BIT])
    else $error("start flag not cleared at completion");
  a_flag_busy: assert property (@(posedge clock) disable iff (reset)
    core.busy |-> flags[START_FLAG_BIT])
    else $error("flag low while converting");
  a_ladder_off: assert property (@(posedge clock) disable iff (reset)
    low_power |=> !ladder_enable)
    else $error("ladder powered in low power");
  a_no_progress: assert property (@(posedge clock) disable iff (reset)
    (low_power && core.busy) |=> $stable(core.code))
    else $error("conversion advanced in low power");
  a_channel_map: assert property (@(posedge clock) disable iff (reset)
    wr_mode |=> analog_input_sel == {$past(reg_wdata[3]), $past(reg_wdata[2])})
    else $error("channel select wrong");
  a_high_nibble: assert property (@(posedge clock) disable iff (reset)
    (reg_read && reg_addr == RESULT_HIGH_ADDR) |=> reg_rdata == $past(core.value[7:4]))
    else $error("upper nibble read wrong");
  a_flags_read: assert property (@(posedge clock) disable iff (reset)
    (reg_read && reg_addr == SHARED_FLAGS_ADDR) |=> reg_rdata == $past(flags))
    else $error("flag register read wrong");

endmodule : adc_sequencer_control

// ==== test/adc_ladder_model.sv ====
// partner model: four analogue input levels and the ladder comparator
// assumes trial code, channel select and ladder enable arrive on clock
`timescale 1ns/1ns
module adc_ladder_model
(
  input  wire logic            clock,
  input  wire logic [3:0][7:0] levels,
  input  wire logic [7:0]      ladder_code,
  input  wire logic [1:0]      analog_input_sel,
  input  wire logic            ladder_enable,
  output      logic            comparator
);
  initial comparator = 1'b0;

  // each level sits half a step above its code, so level >= trial reads above
  always @(posedge clock)
  begin
    if (ladder_enable)
      comparator <= (levels[analog_input_sel] >= ladder_code);
    else
      comparator <= ~comparator;
  end
endmodule : adc_ladder_model

// ==== test/adc_sequencer_control_test.sv ====
// self-checking bench for the converter control
// assumes the ladder model on the analogue side and CYC_DIV of 4
`timescale 1ns/1ns
module adc_sequencer_control_test;
  import adc_pkg::*;
  localparam int              CYC    = 4;
  localparam logic [3:0][7:0] LEVELS = {8'ha5, 8'h5a, 8'hff, 8'h00};
  logic       clock, reset, reg_write, reg_read, low_power, comparator;
  logic [6:0] reg_addr;
  logic [3:0] reg_wdata, reg_rdata, rd;
  logic [7:0] ladder_code, res;
  logic [1:0] analog_input_sel;
  logic       ladder_enable, conversion_busy;
  logic       mode_flag_a, watchdog_enable_flag, low_speed_flag;
  int         n_errors = 0;
  int         n_tests  = 0;

  // ************************************************************
  // design and analogue side
  // ************************************************************
  adc_sequencer_control #(.CYC_DIV(CYC)) i_dut (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .low_power(low_power),
    .comparator(comparator), .ladder_code(ladder_code),
    .analog_input_sel(analog_input_sel), .ladder_enable(ladder_enable),
    .conversion_busy(conversion_busy), .mode_flag_a(mode_flag_a),
    .watchdog_enable_flag(watchdog_enable_flag), .low_speed_flag(low_speed_flag));
  adc_ladder_model i_ladder (.clock(clock), .levels(LEVELS), .ladder_code(ladder_code),
    .analog_input_sel(analog_input_sel), .ladder_enable(ladder_enable),
    .comparator(comparator));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [6:0] a, output logic [3:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_rd

  task automatic read_result(output logic [7:0] r);
    logic [3:0] hi;
    logic [3:0] lo;
    reg_rd(RESULT_HIGH_ADDR, hi);
    reg_rd(RESULT_LOW_ADDR, lo);
    r = {hi, lo};
  endtask : read_result

  // one conversion, optionally paused by a low-power spell of lp+1 clocks
  task automatic convert(input logic [1:0] ch, input logic len, input int lp);
    int cycles;
    int expect_clk;
    cycles     = 0;
    expect_clk = (len ? 67 : 34) * CYC;
    reg_wr(ADC_MODE_REG_ADDR, {ch, 1'b0, len});
    reg_wr(SHARED_FLAGS_ADDR, 4'hf);
    reg_rd(SHARED_FLAGS_ADDR, rd);
    chk(8'(rd), 8'hf);
    chk(8'(analog_input_sel), 8'(ch));
    chk(ladder_code, TRIAL_FIRST);
    if (lp > 0)
    begin
      @(posedge clock);
      low_power <= 1'b1;
      repeat (lp) @(posedge clock);
      #1;
      chk(8'(ladder_enable), 8'h0);
      chk(8'(conversion_busy), 8'h1);
      @(posedge clock);
      low_power <= 1'b0;
      cycles = 2;
    end
    while (conversion_busy === 1'b1 && cycles < 2000)
    begin
      @(posedge clock);
      #1;
      cycles++;
    end
    cycles += 2;
    chk(8'(cycles >= expect_clk - CYC && cycles <= expect_clk + 3 * CYC), 8'h1);
    // result is only read once the flag has dropped
    read_result(res);
    chk(res, LEVELS[ch]);
    reg_rd(SHARED_FLAGS_ADDR, rd);
    chk(8'(rd), 8'hb);
  endtask : convert

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // ************************************************************
  // clock, watchdog and test sequence
  // ************************************************************
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // cuts a hang short well beyond the expected few thousand clocks
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    give_verdict();
  end

  // main sequence
  initial
  begin
    reset     = 1'b1;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 4'h0;
    low_power = 1'b0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    reg_rd(SHARED_FLAGS_ADDR, rd);
    chk(8'(rd), 8'h0);
    chk(8'({mode_flag_a, watchdog_enable_flag, low_speed_flag}), 8'h0);
    chk(8'(ladder_enable), 8'h1);
    reg_rd(ADC_MODE_REG_ADDR, rd);
    chk(8'(rd), 8'h0);
    reg_rd(7'h7f, rd);
    chk(8'(rd), 8'h0);
    reg_wr(SHARED_FLAGS_ADDR, 4'hb);
    reg_rd(SHARED_FLAGS_ADDR, rd);
    chk(8'(rd), 8'hb);
    chk(8'({mode_flag_a, watchdog_enable_flag, low_speed_flag}), 8'h7);
    $display("test reset and flags done");
    for (int k = 0; k < 8; k++)
      convert(2'(k >> 1), k[0], 0);
    $display("test channels and periods done");
    repeat (50) @(posedge clock);
    reg_wr(RESULT_LOW_ADDR, 4'h0);
    reg_wr(RESULT_HIGH_ADDR, 4'h0);
    read_result(res);
    chk(res, LEVELS[3]);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    read_result(res);
    chk(res, LEVELS[3]);
    reg_rd(SHARED_FLAGS_ADDR, rd);
    chk(8'(rd), 8'h0);
    $display("test result hold done");
    convert(2'd2, 1'b1, 300);
    chk(8'(ladder_enable), 8'h1);
    $display("test low power done");
    give_verdict();
  end
endmodule : adc_sequencer_control_test
